//--- bhsc_pkg.sv
package bhsc_pkg;

  // data address generator register kinds
  localparam logic [1:0] DAG_KIND_IDX = 2'h0;
  localparam logic [1:0] DAG_KIND_MOD = 2'h1;
  localparam logic [1:0] DAG_KIND_BASE = 2'h2;
  localparam logic [1:0] DAG_KIND_LEN = 2'h3;

  // flag source bit positions within flag_wr
  localparam int FLAG_ALU = 0;
  localparam int FLAG_MUL = 1;
  localparam int FLAG_BTF = 2;

  typedef enum logic [1:0] {
    COND_NONE = 2'b00,
    COND_ALU = 2'b01,
    COND_MUL = 2'b10,
    COND_BTF = 2'b11
  } bhsc_cond_e;

  // stall and overhead counts in cycles
  localparam logic [1:0] STALL_NONE = 2'h0;
  localparam logic [1:0] STALL_ONE = 2'h1;
  localparam logic [1:0] STALL_TWO = 2'h2;
  localparam logic [1:0] BR_OVERHEAD = 2'h3;

  // loop body lengths that need a settling cycle
  localparam logic [15:0] LOOP_LEN_ONE = 16'h0001;
  localparam logic [15:0] LOOP_LEN_TWO = 16'h0002;
  localparam logic [15:0] LOOP_LEN_FOUR = 16'h0004;

  typedef struct packed {
    logic valid;
    logic dag_wr;
    logic [1:0] dag_kind;
    logic [3:0] dag_num;
    logic ag_use;
    logic [3:0] ag_idx;
    logic [3:0] ag_mod;
    logic ind_br;
    logic cond_br;
    bhsc_cond_e cond_src;
    logic [2:0] flag_wr;
    logic stat_wr;
    logic lce_dep;
    logic cpm;
    logic fp_mul;
    logic fx_use;
    logic loop_abort;
    logic loop_short;
    logic ret;
    logic ret_loop_end;
  } bhsc_ins_s;

  typedef struct packed {
    bhsc_ins_s dec;
    bhsc_ins_s adr;
    bhsc_ins_s exe;
    logic [1:0] stall_cnt;
    logic [1:0] flush_cnt;
    logic hold;
    logic flush;
    logic pc_pop;
  } bhsc_state_s;

endpackage : bhsc_pkg

//--- bhsc_dag_match.sv
`timescale 1ns/1ps
module bhsc_dag_match
  import bhsc_pkg::*;
(
  input wire logic prod_valid,
  input wire logic prod_dag_wr,
  input wire logic [1:0] prod_kind,
  input wire logic [3:0] prod_num,
  input wire logic cons_ind_br,
  input wire logic [3:0] cons_idx,
  input wire logic [3:0] cons_mod,
  output logic hit
);

  logic wr_ok;

  assign wr_ok = prod_valid && prod_dag_wr && cons_ind_br;

  // modify registers match only themselves; index, base and length
  // share the index number of the same generator
  always_comb begin
    if (prod_kind == DAG_KIND_MOD) begin
      hit = wr_ok && (prod_num == cons_mod);
    end else begin
      hit = wr_ok && (prod_num == cons_idx);
    end
  end

endmodule : bhsc_dag_match

//--- bhsc_flag_dep.sv
`timescale 1ns/1ps
module bhsc_flag_dep
  import bhsc_pkg::*;
(
  input wire logic prod_valid,
  input wire logic [2:0] prod_flag_wr,
  input wire logic prod_stat_wr,
  input wire logic cons_cond_br,
  input wire bhsc_cond_e cons_cond,
  output logic dep
);

  logic src_hit;

  // explicit status writes touch every flag source
  always_comb begin
    unique case (cons_cond)
      COND_ALU: src_hit = prod_flag_wr[FLAG_ALU];
      COND_MUL: src_hit = prod_flag_wr[FLAG_MUL];
      COND_BTF: src_hit = prod_flag_wr[FLAG_BTF];
      COND_NONE: src_hit = 1'b0;
    endcase
  end

  assign dep = prod_valid && cons_cond_br && (src_hit || prod_stat_wr);

endmodule : bhsc_flag_dep

//--- bhsc_stall_ctrl.sv
`timescale 1ns/1ps
// Notes on behaviour
// - five stages fetch1, fetch2, decode, address, execute; loads land end of execute
// - indirect branch right after its generator register load stalls two cycles
// - one unrelated instruction between load and indirect branch gives one stall
// - producer keeps moving; dependent and younger instructions wait behind it
// - taken jump or call costs three overhead cycles after any hazard stall
// - conditional branch right after a flag-setting compute stalls one cycle
// - taken conditional return adds three overhead cycles and pops the return stack
// - multiplier flag condition after a multiplier compute adds one more stall
// - not-expired loop branch followed by a loop-count changer stalls two cycles
// - same loop-count dependency on a non-branch stalls one cycle only
// - normal loop-back decrement never raises a loop-count stall
// - flag write, conditional post-modify, then same index use stalls two
// - one gap in that chain gives one stall, two gaps give none
// - flag dependency matches only the source that drives the condition, or an explicit status write
// - several causes at once may cost extra cycles; here they merge by max
// - fixed-point compute right after a float multiply stalls one cycle
// - loop-abort jump stalls one cycle while in the address stage
// - counted loop setup for a one, two or four instruction body stalls one cycle
// - return landing on a loop end stalls one cycle in the address stage
// - modify register load stalls only on reuse of that same register
module bhsc_stall_ctrl
  import bhsc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic f2_valid,
  input wire logic f2_dag_wr,
  input wire logic [1:0] f2_dag_kind,
  input wire logic [3:0] f2_dag_num,
  input wire logic f2_ag_use,
  input wire logic [3:0] f2_ag_idx,
  input wire logic [3:0] f2_ag_mod,
  input wire logic f2_ind_br,
  input wire logic f2_cond_br,
  input wire bhsc_cond_e f2_cond_src,
  input wire logic [2:0] f2_flag_wr,
  input wire logic f2_stat_wr,
  input wire logic f2_lce_dep,
  input wire logic f2_cpm,
  input wire logic f2_fp_mul,
  input wire logic f2_fx_use,
  input wire logic f2_loop_abort,
  input wire logic f2_loop_setup,
  input wire logic f2_loop_ctr,
  input wire logic [15:0] f2_loop_len,
  input wire logic f2_ret,
  input wire logic f2_ret_loop_end,
  input wire logic f1_lce_chg,
  input wire logic adr_taken,
  output logic hold_front,
  output logic flush_front,
  output logic pc_pop,
  output logic adr_valid,
  output logic exe_valid
);

  bhsc_state_s s_q;
  bhsc_state_s s_d;
  bhsc_ins_s nx;
  logic hit1;
  logic hit2;
  logic dep1;
  logic taken;
  logic shift;
  logic fm2;
  logic fm3;
  logic same1;
  logic same2;
  logic [1:0] st_dag;
  logic [1:0] st_flag;
  logic [1:0] st_lce;
  logic [1:0] st_cpm;
  logic [1:0] st_misc;
  logic [1:0] n_stall;

  function automatic logic [1:0] max2(input logic [1:0] a,
                                      input logic [1:0] b);
    max2 = (a > b) ? a : b;
  endfunction : max2

  // instruction arriving from fetch2 into decode
  always_comb begin
    nx = '0;
    nx.valid = f2_valid;
    nx.dag_wr = f2_dag_wr;
    nx.dag_kind = f2_dag_kind;
    nx.dag_num = f2_dag_num;
    nx.ag_use = f2_ag_use;
    nx.ag_idx = f2_ag_idx;
    nx.ag_mod = f2_ag_mod;
    nx.ind_br = f2_ind_br;
    nx.cond_br = f2_cond_br;
    nx.cond_src = f2_cond_src;
    nx.flag_wr = f2_flag_wr;
    nx.stat_wr = f2_stat_wr;
    nx.lce_dep = f2_lce_dep;
    nx.cpm = f2_cpm;
    nx.fp_mul = f2_fp_mul;
    nx.fx_use = f2_fx_use;
    nx.loop_abort = f2_loop_abort;
    nx.loop_short = f2_loop_setup && f2_loop_ctr &&
                    (f2_loop_len == LOOP_LEN_ONE ||
                     f2_loop_len == LOOP_LEN_TWO ||
                     f2_loop_len == LOOP_LEN_FOUR);
    nx.ret = f2_ret;
    nx.ret_loop_end = f2_ret_loop_end;
  end

  // decode instruction moves to address, so it is one ahead of nx
  bhsc_dag_match u_dag_near (
    .prod_valid(s_q.dec.valid),
    .prod_dag_wr(s_q.dec.dag_wr),
    .prod_kind(s_q.dec.dag_kind),
    .prod_num(s_q.dec.dag_num),
    .cons_ind_br(nx.ind_br),
    .cons_idx(nx.ag_idx),
    .cons_mod(nx.ag_mod),
    .hit(hit1)
  );

  bhsc_dag_match u_dag_far (
    .prod_valid(s_q.adr.valid),
    .prod_dag_wr(s_q.adr.dag_wr),
    .prod_kind(s_q.adr.dag_kind),
    .prod_num(s_q.adr.dag_num),
    .cons_ind_br(nx.ind_br),
    .cons_idx(nx.ag_idx),
    .cons_mod(nx.ag_mod),
    .hit(hit2)
  );

  bhsc_flag_dep u_flag_dep (
    .prod_valid(s_q.dec.valid),
    .prod_flag_wr(s_q.dec.flag_wr),
    .prod_stat_wr(s_q.dec.stat_wr),
    .cons_cond_br(nx.cond_br),
    .cons_cond(nx.cond_src),
    .dep(dep1)
  );

  assign taken = s_q.adr.valid && adr_taken;
  assign shift = !taken && s_q.stall_cnt == STALL_NONE &&
                 s_q.flush_cnt == STALL_NONE;

  // any flag writer two or three slots ahead
  assign fm2 = s_q.adr.valid && ((|s_q.adr.flag_wr) || s_q.adr.stat_wr);
  assign fm3 = s_q.exe.valid && ((|s_q.exe.flag_wr) || s_q.exe.stat_wr);
  assign same1 = s_q.dec.valid && s_q.dec.cpm &&
                 s_q.dec.ag_idx == nx.ag_idx;
  assign same2 = s_q.adr.valid && s_q.adr.cpm &&
                 s_q.adr.ag_idx == nx.ag_idx;

  always_comb begin
    st_dag = STALL_NONE;
    if (nx.valid && hit1) begin
      st_dag = STALL_TWO;
    end else if (nx.valid && hit2) begin
      st_dag = STALL_ONE;
    end
    st_flag = STALL_NONE;
    if (nx.valid && dep1) begin
      // flags sampled in address, written at end of execute
      st_flag = (nx.cond_src == COND_MUL) ? STALL_TWO : STALL_ONE;
    end
    st_lce = STALL_NONE;
    // only instruction-driven changes assert f1_lce_chg, never loop-back
    if (nx.valid && nx.lce_dep && f1_lce_chg) begin
      st_lce = nx.cond_br ? STALL_TWO : STALL_ONE;
    end
    st_cpm = STALL_NONE;
    if (nx.valid && nx.ag_use) begin
      if (same1 && fm2) begin
        st_cpm = STALL_TWO;
      end else if ((same1 && fm3) || (same2 && fm3)) begin
        st_cpm = STALL_ONE;
      end
    end
    st_misc = STALL_NONE;
    if (nx.valid && nx.fx_use && s_q.dec.valid && s_q.dec.fp_mul) begin
      st_misc = STALL_ONE;
    end
    // these sit in address next cycle and hold everything behind
    if (s_q.dec.valid && (s_q.dec.loop_abort || s_q.dec.loop_short ||
                          s_q.dec.ret_loop_end)) begin
      st_misc = STALL_ONE;
    end
    // causes merge by maximum; cheaper than summing, still covers all
    n_stall = max2(max2(st_dag, st_flag),
                   max2(st_lce, max2(st_cpm, st_misc)));
  end

  always_comb begin
    s_d = s_q;
    s_d.pc_pop = 1'b0;
    if (taken) begin
      // younger work behind a taken branch is dropped
      s_d.exe = s_q.adr;
      s_d.adr = '0;
      s_d.dec = '0;
      s_d.stall_cnt = STALL_NONE;
      // count covers all three overhead cycles so fetch stays refused
      s_d.flush_cnt = BR_OVERHEAD;
      s_d.flush = 1'b1;
      s_d.hold = 1'b0;
      s_d.pc_pop = s_q.adr.ret;
    end else if (s_q.flush_cnt != STALL_NONE) begin
      s_d.exe = s_q.adr;
      s_d.adr = s_q.dec;
      s_d.dec = '0;
      s_d.flush_cnt = s_q.flush_cnt - STALL_ONE;
      s_d.flush = (s_q.flush_cnt != STALL_ONE);
      s_d.hold = 1'b0;
    end else if (s_q.stall_cnt != STALL_NONE) begin
      // producer drains, dependent waits in decode
      s_d.exe = s_q.adr;
      s_d.adr = '0;
      s_d.stall_cnt = s_q.stall_cnt - STALL_ONE;
      s_d.hold = (s_q.stall_cnt != STALL_ONE);
      s_d.flush = 1'b0;
    end else begin
      // normal advance of the five stage flow
      s_d.exe = s_q.adr;
      s_d.adr = s_q.dec;
      s_d.dec = nx;
      s_d.stall_cnt = n_stall;
      s_d.hold = (n_stall != STALL_NONE);
      s_d.flush = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign hold_front = s_q.hold;
  assign flush_front = s_q.flush;
  assign pc_pop = s_q.pc_pop;
  assign adr_valid = s_q.adr.valid;
  assign exe_valid = s_q.exe.valid;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);

  a_dag_near_two: assert property (
    shift && nx.valid && hit1 |=> hold_front ##1 hold_front
  ) else $error("dag load before branch did not stall two cycles");

  a_dag_far_one: assert property (
    shift && n_stall == STALL_ONE && nx.valid && hit2
      |=> hold_front ##1 !hold_front
  ) else $error("dag load two ahead did not stall exactly one cycle");

  a_producer_moves: assert property (
    hold_front && !taken |=> s_q.exe == $past(s_q.adr)
  ) else $error("producer did not advance during stall");

  a_front_held: assert property (
    hold_front && !taken |=> s_q.dec == $past(s_q.dec) && !s_q.adr.valid
  ) else $error("decode not held or address not bubbled");

  a_flush_three: assert property (
    taken |=> flush_front [*3] ##1 !flush_front
  ) else $error("taken branch overhead not three cycles");

  a_ret_pop_once: assert property (
    taken && s_q.adr.ret |=> pc_pop ##1 !pc_pop
  ) else $error("return did not pop the stack once");

  a_mul_flag_two: assert property (
    shift && nx.valid && dep1 && nx.cond_src == COND_MUL
      |=> hold_front [*2]
  ) else $error("multiplier flag branch missed extra stall");

  a_lce_branch_two: assert property (
    shift && nx.valid && nx.lce_dep && f1_lce_chg && nx.cond_br
      |=> hold_front [*2]
  ) else $error("loop count branch did not stall two cycles");

  a_fp_fix_one: assert property (
    shift && nx.valid && nx.fx_use && s_q.dec.valid && s_q.dec.fp_mul
      |=> hold_front
  ) else $error("fixed op after float multiply did not stall");

  a_loop_abort_one: assert property (
    shift && s_q.dec.valid && s_q.dec.loop_abort |=> hold_front
  ) else $error("loop abort jump did not stall in address");

  a_flag_alu_one: assert property (
    shift && nx.valid && dep1 && nx.cond_src != COND_MUL &&
      n_stall == STALL_ONE |=> hold_front ##1 !hold_front
  ) else $error("flag dependent branch did not stall one cycle");

  a_lce_plain_one: assert property (
    shift && nx.valid && nx.lce_dep && f1_lce_chg && !nx.cond_br &&
      n_stall == STALL_ONE |=> hold_front ##1 !hold_front
  ) else $error("loop count non-branch did not stall one cycle");

  a_cpm_near_two: assert property (
    shift && nx.valid && nx.ag_use && same1 && fm2
      |=> hold_front [*2]
  ) else $error("post-modify chain did not stall two cycles");

  a_cpm_gap_one: assert property (
    shift && nx.valid && nx.ag_use && !(same1 && fm2) &&
      (same1 || same2) && fm3 && n_stall == STALL_ONE
      |=> hold_front ##1 !hold_front
  ) else $error("post-modify chain with gap did not stall one cycle");

  a_flag_src_only: assert property (
    shift && nx.valid && nx.cond_br && nx.cond_src == COND_ALU &&
      s_q.dec.valid && !s_q.dec.stat_wr && !s_q.dec.flag_wr[FLAG_ALU]
      |-> st_flag == STALL_NONE
  ) else $error("flag stall raised by a foreign flag source");

  a_no_cause_run: assert property (
    shift && n_stall == STALL_NONE |=> !hold_front
  ) else $error("stall raised with no cause");

  a_short_loop_one: assert property (
    shift && s_q.dec.valid && s_q.dec.loop_short |=> hold_front
  ) else $error("short counted loop setup did not stall");

  a_ret_loop_one: assert property (
    shift && s_q.dec.valid && s_q.dec.ret_loop_end |=> hold_front
  ) else $error("return to loop end did not stall");

  a_flush_nop: assert property (
    flush_front |=> !s_q.dec.valid
  ) else $error("decode not emptied during branch overhead");

  c_dag_stall: cover property (shift && nx.valid && hit1 ##3 shift);
  c_taken_ret: cover property (taken && s_q.adr.ret);
  c_cpm_two: cover property (shift && st_cpm == STALL_TWO);
  c_stall_then_flush: cover property (hold_front ##[1:4] taken);

endmodule : bhsc_stall_ctrl

//--- bhsc_tb.sv
`timescale 1ns/1ps
module testbench;
  import bhsc_pkg::*;
  typedef struct packed {
    bhsc_ins_s p;
    logic [1:0] gap;
    bhsc_ins_s q;
    bhsc_ins_s c;
    logic chg;
    logic ctr;
    logic [15:0] len;
    logic [1:0] exp;
  } bhsc_row_s;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  bhsc_ins_s ins = '0;
  logic loop_ctr = 1'b0;
  logic [15:0] loop_len = 16'h0000;
  logic lce_chg = 1'b0;
  logic adr_taken = 1'b0;
  logic hold_front, flush_front, pc_pop, adr_valid, exe_valid;
  int num_errors = 0;
  int total_checks = 0;
  int hold_n, flush_n, pop_n, exe_n, sent;
  bhsc_row_s rows[$];
  bhsc_ins_s t, u;

  bhsc_stall_ctrl dut_u (
    .sys_clk(sys_clk), .nrst(nrst), .f2_valid(ins.valid),
    .f2_dag_wr(ins.dag_wr), .f2_dag_kind(ins.dag_kind),
    .f2_dag_num(ins.dag_num), .f2_ag_use(ins.ag_use),
    .f2_ag_idx(ins.ag_idx), .f2_ag_mod(ins.ag_mod),
    .f2_ind_br(ins.ind_br), .f2_cond_br(ins.cond_br),
    .f2_cond_src(ins.cond_src), .f2_flag_wr(ins.flag_wr),
    .f2_stat_wr(ins.stat_wr), .f2_lce_dep(ins.lce_dep), .f2_cpm(ins.cpm),
    .f2_fp_mul(ins.fp_mul), .f2_fx_use(ins.fx_use),
    .f2_loop_abort(ins.loop_abort), .f2_loop_setup(ins.loop_short),
    .f2_loop_ctr(loop_ctr), .f2_loop_len(loop_len), .f2_ret(ins.ret),
    .f2_ret_loop_end(ins.ret_loop_end), .f1_lce_chg(lce_chg),
    .adr_taken(adr_taken), .hold_front(hold_front),
    .flush_front(flush_front), .pc_pop(pc_pop), .adr_valid(adr_valid),
    .exe_valid(exe_valid)
  );

  initial begin
    forever #50 sys_clk = ~sys_clk;
  end

  // pre-edge values, so counts see what the design saw
  always @(posedge sys_clk) begin
    hold_n += int'(hold_front === 1'b1);
    flush_n += int'(flush_front === 1'b1);
    pop_n += int'(pc_pop === 1'b1);
    exe_n += int'(exe_valid === 1'b1);
  end

  function automatic bhsc_ins_s nop();
    nop = '0;
    nop.valid = 1'b1;
  endfunction : nop

  function automatic bhsc_ins_s dld(logic [1:0] k, logic [3:0] n);
    dld = nop();
    dld.dag_wr = 1'b1;
    dld.dag_kind = k;
    dld.dag_num = n;
  endfunction : dld

  function automatic bhsc_ins_s ibr(logic [3:0] i, logic [3:0] m);
    ibr = nop();
    ibr.ind_br = 1'b1;
    ibr.ag_idx = i;
    ibr.ag_mod = m;
  endfunction : ibr

  function automatic bhsc_ins_s fw(logic [2:0] f);
    fw = nop();
    fw.flag_wr = f;
  endfunction : fw

  function automatic bhsc_ins_s cbr(bhsc_cond_e s);
    cbr = nop();
    cbr.cond_br = 1'b1;
    cbr.cond_src = s;
  endfunction : cbr

  task automatic add(bhsc_ins_s p, logic [1:0] g, bhsc_ins_s q,
                     bhsc_ins_s c, logic chg, logic ctr, logic [15:0] len,
                     logic [1:0] e);
    rows.push_back('{p, g, q, c, chg, ctr, len, e});
  endtask : add

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report

  task automatic chk(string what, int got, int e);
    total_checks++;
    if (got != e) begin
      num_errors++;
      $display("mismatch at %0t: %s got %0d want %0d", $time, what, got, e);
    end
  endtask : chk

  task automatic chk_bits(string what, logic [4:0] got, logic [4:0] e);
    total_checks++;
    if (got !== e) begin
      num_errors++;
      $display("mismatch at %0t: %s got %b want %b", $time, what, got, e);
    end
  endtask : chk_bits

  // a fetch slot is only consumed on an edge with no hold and no flush
  task automatic put(bhsc_ins_s i, logic chg);
    int k;
    ins <= i;
    lce_chg <= chg;
    for (k = 0; k < 20; k++) begin
      @(posedge sys_clk);
      if (hold_front === 1'b0 && flush_front === 1'b0) begin
        break;
      end
    end
    if (k == 20) begin
      num_errors++;
      $display("mismatch at %0t: instruction never taken", $time);
      final_report();
    end
  endtask : put

  task automatic clr();
    @(negedge sys_clk);
    hold_n = 0;
    flush_n = 0;
    pop_n = 0;
    exe_n = 0;
    @(posedge sys_clk);
  endtask : clr

  task automatic run_row(bhsc_row_s x);
    int g;
    clr();
    loop_ctr <= x.ctr;
    loop_len <= x.len;
    put(x.p, 1'b0);
    sent = 1;
    for (g = 0; g < x.gap; g++) begin
      put(nop(), 1'b0);
      sent++;
    end
    if (x.q.valid) begin
      put(x.q, 1'b0);
      sent++;
    end
    put(x.c, x.chg);
    sent += int'(x.c.valid);
    put('0, 1'b0);
    repeat (8) @(posedge sys_clk);
    chk("stall cycles", hold_n, int'(x.exp));
    chk("executed", exe_n, sent);
    $display("row test done");
  endtask : run_row

  // the branch is taken on the edge where it sits in the address stage
  task automatic br(bhsc_ins_s p, bhsc_ins_s c, int eh, int ep);
    int k;
    clr();
    put(p, 1'b0);
    put(c, 1'b0);
    ins <= '0;
    for (k = 0; k < 8; k++) begin
      @(posedge sys_clk);
      if (hold_front === 1'b0) begin
        break;
      end
    end
    chk("hold wait", k, eh);
    adr_taken <= 1'b1;
    @(posedge sys_clk);
    chk_bits("branch in address", {4'h0, adr_valid}, 5'h01);
    adr_taken <= 1'b0;
    repeat (8) @(posedge sys_clk);
    chk("stall cycles", hold_n, eh);
    chk("overhead cycles", flush_n, int'(BR_OVERHEAD));
    chk("stack pops", pop_n, ep);
    $display("branch test done");
  endtask : br

  initial begin
    add(dld(DAG_KIND_MOD, 4'h8), 0, '0, ibr(4'h9, 4'h8),
        0, 0, 0, STALL_TWO);
    add(dld(DAG_KIND_MOD, 4'h8), 1, '0, ibr(4'h9, 4'h8),
        0, 0, 0, STALL_ONE);
    add(dld(DAG_KIND_MOD, 4'h8), 2, '0, ibr(4'h9, 4'h8),
        0, 0, 0, 0);
    add(dld(DAG_KIND_MOD, 4'h2), 0, '0, ibr(4'h2, 4'h0),
        0, 0, 0, 0);
    add(dld(DAG_KIND_LEN, 4'h2), 0, '0, ibr(4'h2, 4'h0),
        0, 0, 0, 2);
    add(fw(3'h1), 0, '0, cbr(COND_ALU), 0, 0, 0, STALL_ONE);
    add(fw(3'h2), 0, '0, cbr(COND_MUL), 0, 0, 0, STALL_TWO);
    add(fw(3'h1), 0, '0, cbr(COND_MUL), 0, 0, 0, STALL_NONE);
    add(fw(3'h4), 0, '0, cbr(COND_BTF), 0, 0, 0, STALL_ONE);
    t = nop();
    t.stat_wr = 1'b1;
    add(t, 0, '0, cbr(COND_ALU), 0, 0, 0, STALL_ONE);
    t = cbr(COND_NONE);
    t.lce_dep = 1'b1;
    add(nop(), 0, '0, t, 1, 0, 0, STALL_TWO);
    add(nop(), 0, '0, t, 0, 0, 0, STALL_NONE);
    t.cond_br = 1'b0;
    add(nop(), 0, '0, t, 1, 0, 0, STALL_ONE);
    t = nop();
    t.fp_mul = 1'b1;
    u = nop();
    u.fx_use = 1'b1;
    add(t, 0, '0, u, 0, 0, 0, STALL_ONE);
    add(t, 1, '0, u, 0, 0, 0, STALL_NONE);
    t = nop();
    t.cpm = 1'b1;
    t.ag_use = 1'b1;
    t.ag_idx = 4'h1;
    u = nop();
    u.ag_use = 1'b1;
    u.ag_idx = 4'h1;
    add(fw(3'h1), 0, t, u, 0, 0, 0, STALL_TWO);
    add(fw(3'h1), 1, t, u, 0, 0, 0, STALL_ONE);
    add(fw(3'h1), 2, t, u, 0, 0, 0, STALL_NONE);
    t = dld(DAG_KIND_MOD, 4'h8);
    t.flag_wr = 3'h1;
    u = ibr(4'h9, 4'h8);
    u.cond_br = 1'b1;
    u.cond_src = COND_ALU;
    add(t, 0, '0, u, 0, 0, 0, STALL_TWO);
    t = nop();
    t.loop_abort = 1'b1;
    add(t, 0, '0, nop(), 0, 0, 0, STALL_ONE);
    t = nop();
    t.loop_short = 1'b1;
    add(t, 0, '0, nop(), 0, 1, LOOP_LEN_ONE, STALL_ONE);
    add(t, 0, '0, nop(), 0, 1, LOOP_LEN_TWO, STALL_ONE);
    add(t, 0, '0, nop(), 0, 1, LOOP_LEN_FOUR, STALL_ONE);
    add(t, 0, '0, nop(), 0, 1, 16'h0003, STALL_NONE);
    add(t, 0, '0, nop(), 0, 0, LOOP_LEN_ONE, STALL_NONE);
    t = nop();
    t.ret = 1'b1;
    t.ret_loop_end = 1'b1;
    add(t, 0, '0, nop(), 0, 0, 0, STALL_ONE);
    repeat (4) @(posedge sys_clk);
    chk_bits("reset outputs", {hold_front, flush_front, pc_pop, adr_valid,
             exe_valid}, 5'h00);
    nrst <= 1'b1;
    foreach (rows[i]) begin
      run_row(rows[i]);
    end
    br(dld(DAG_KIND_MOD, 4'h8), ibr(4'h9, 4'h8), 2, 0);
    t = cbr(COND_ALU);
    t.ret = 1'b1;
    br(fw(3'h1), t, 1, 1);
    // reset in the middle of a stall must clear everything
    put(dld(DAG_KIND_MOD, 4'h8), 1'b0);
    put(ibr(4'h9, 4'h8), 1'b0);
    nrst <= 1'b0;
    ins <= '0;
    repeat (2) @(posedge sys_clk);
    chk_bits("mid reset outputs", {hold_front, flush_front, pc_pop,
             adr_valid, exe_valid}, 5'h00);
    nrst <= 1'b1;
    $display("reset test done");
    final_report();
  end
endmodule : testbench
